/* common/lms_pkg.sv */
/*
 * lms_pkg: shared constants and types of the list mode sequencer.
 * assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
package lms_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] LMS_A_CTRL = 8'h00; // mode bits
    localparam logic [7:0] LMS_A_COUNT = 8'h04; // repeat count
    localparam logic [7:0] LMS_A_CMD = 8'h08; // trigger / stop pulses
    localparam logic [7:0] LMS_A_STAT = 8'h0C; // run state
    localparam logic [7:0] LMS_A_SEL = 8'h10; // entry and phase select
    localparam logic [7:0] LMS_A_FLD = 8'h20; // first entry field
    localparam logic [3:0] LMS_NFLD = 4'h9; // fields 0x20..0x40
    // ctrl / cmd / sel field positions
    localparam int LMS_C_TRIG = 0; // [1:0] trigger method
    localparam int LMS_C_COUPLE = 2; // 1 = joint coupling
    localparam int LMS_C_CONT = 3; // 1 = angle continuity
    localparam int LMS_C_BASE = 4; // 1 = duration in cycles
    localparam int LMS_K_TRIG = 0; // cmd: software trigger
    localparam int LMS_K_STOP = 1; // cmd: stop
    localparam int LMS_S_PH = 8; // sel [9:8] phase
    // ------------------------------------------------------------
    // sizes, reset values, timing
    // ------------------------------------------------------------
    localparam logic [6:0] LMS_NENT = 7'h63; // 99 entries
    localparam logic [15:0] LMS_COUNT_RST = 16'h0001;
    localparam logic [15:0] LMS_OFF_P2 = 16'hAAAB; // +240 deg
    localparam logic [15:0] LMS_OFF_P3 = 16'h5555; // +120 deg
    localparam int LMS_CLK_NS = 20; // aclk period
    localparam int LMS_TICK_NS = 1000000; // duration time unit 1 ms
    localparam int LMS_TICK_CYC = LMS_TICK_NS / LMS_CLK_NS;
    // angle step per ms per 0.01 Hz, 2^32 / 100000
    localparam logic [16:0] LMS_PHASE_K = 17'h0A7C6;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LMS_TRIG_AUTO = 2'b00,
        LMS_TRIG_MANUAL = 2'b01,
        LMS_TRIG_EXT = 2'b10
    } lms_trig_e;
    typedef enum logic {
        LMS_IDLE = 1'b0,
        LMS_RUN = 1'b1
    } lms_state_e;
    typedef struct packed {
        logic [15:0] vac_s; // start amplitude
        logic [15:0] vac_e; // end amplitude
        logic [15:0] f_s; // start frequency, 0.01 Hz
        logic [15:0] f_e; // end frequency
        logic [15:0] vdc_s; // start offset
        logic [15:0] vdc_e; // end offset
        logic [15:0] deg; // start angle, full turn = 2^16
        logic [15:0] dur; // duration, ms or cycles
        logic wave; // waveform choice
    } lms_entry_s;
    typedef struct packed {
        logic [15:0] vac; // amplitude
        logic [15:0] freq; // frequency
        logic [15:0] vdc; // offset
        logic [15:0] angle; // angle
        logic wave; // waveform
    } lms_out_s;
endpackage : lms_pkg

/* rtl/lms_seq.sv */
/*
 * lms_seq: list mode sequencer with AXI4-Lite registers.
 * assumes ext_trig is synchronous to aclk; outputs feed a waveform
 * synthesiser per phase and the output stage enable.
 */
`timescale 1ns/10ps
module lms_seq #(
    parameter int TICK_CYC = lms_pkg::LMS_TICK_CYC // cycles per ms
) (
    input wire logic aclk, // clock, 50 MHz
    input wire logic aresetn, // synchronous reset, low
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [7:0] awaddr, // write address
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write strobes
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    output logic [1:0] bresp, // write response
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    input wire logic [7:0] araddr, // read address
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    input wire logic ext_trig, // external trigger, high
    output logic out_en, // output stage enable
    output lms_pkg::lms_out_s ph_out [3] // per phase setpoints
);
    import lms_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    lms_entry_s tbl_q [3][99]; // entry table per phase
    logic [4:0] ctrl_q; // mode bits
    logic [15:0] count_q; // repeat count
    logic [9:0] sel_q; // phase and entry select
    lms_state_e st_q; // run state
    logic [6:0] idx_q; // current entry
    logic [15:0] rep_q; // finished passes
    logic [15:0] el_q; // elapsed units in entry
    logic [31:0] tick_q; // ms prescaler
    logic [31:0] acc_q [3]; // phase accumulators
    logic [31:0] acc_d [3]; // advanced accumulators
    logic ext_q; // previous external trigger
    logic aw_q, w_q; // address / data held
    logic [7:0] awa_q; // held write address
    logic [31:0] wd_q; // held write data
    logic [31:0] rdata_q; // read data register
    logic wr_go, sw_trig, sw_stop; // write strobes
    logic trig, tick, wrap, step, last; // sequencing events
    logic [6:0] nidx; // next entry index
    logic pass_end, run_end, ent_go; // boundaries
    logic [6:0] go_idx; // entry that begins now
    lms_trig_e mode; // trigger method

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // read one field of an entry
    function automatic logic [15:0] get_fld(lms_entry_s e,
                                            logic [3:0] f);
        logic [15:0] v;
        v = 16'h0000;
        unique case (f)
            4'h0: v = e.vac_s;
            4'h1: v = e.vac_e;
            4'h2: v = e.f_s;
            4'h3: v = e.f_e;
            4'h4: v = e.vdc_s;
            4'h5: v = e.vdc_e;
            4'h6: v = e.deg;
            4'h7: v = e.dur;
            4'h8: v = {15'h0000, e.wave};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : get_fld

    // linear ramp from s to e at el of d units
    function automatic logic [15:0] lerp(logic [15:0] s,
                                         logic [15:0] e,
                                         logic [15:0] el,
                                         logic [15:0] d);
        logic signed [33:0] p;
        p = ($signed({1'b0, e}) - $signed({1'b0, s}))
            * $signed({1'b0, el});
        if (d != 16'h0000) begin
            p = p / $signed({18'h00000, d});
        end
        return 16'(s + p[15:0]);
    endfunction : lerp

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign awready = !aw_q && !bvalid;
    assign wready = !w_q && !bvalid;
    assign arready = !rvalid;
    assign bresp = 2'b00;
    assign rresp = 2'b00;
    assign rdata = rdata_q;
    assign wr_go = aw_q && w_q && !bvalid;
    assign sw_trig = wr_go && awa_q == LMS_A_CMD && wd_q[LMS_K_TRIG];
    assign sw_stop = wr_go && awa_q == LMS_A_CMD && wd_q[LMS_K_STOP];

    // hold address and data in either order, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            bvalid <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                awa_q <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wd_q <= wdata;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid <= 1'b1;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; wstrb is ignored, whole words written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 5'h00;
            count_q <= LMS_COUNT_RST;
            sel_q <= 10'h000;
        end else if (wr_go) begin
            if (awa_q == LMS_A_CTRL) begin
                ctrl_q <= wd_q[4:0];
            end
            if (awa_q == LMS_A_COUNT) begin
                count_q <= wd_q[15:0];
            end
            if (awa_q == LMS_A_SEL) begin
                sel_q <= wd_q[9:0];
            end
        end
    end

    // entry table written through select plus field offset
    always_ff @(posedge aclk) begin
        logic [3:0] f;
        f = 4'(awa_q[7:2] - LMS_A_FLD[7:2]);
        if (wr_go && awa_q >= LMS_A_FLD && f < LMS_NFLD
            && sel_q[6:0] < LMS_NENT && sel_q[9:8] != 2'b11) begin
            unique case (f)
                4'h0: tbl_q[sel_q[9:8]][sel_q[6:0]].vac_s <= wd_q[15:0];
                4'h1: tbl_q[sel_q[9:8]][sel_q[6:0]].vac_e <= wd_q[15:0];
                4'h2: tbl_q[sel_q[9:8]][sel_q[6:0]].f_s <= wd_q[15:0];
                4'h3: tbl_q[sel_q[9:8]][sel_q[6:0]].f_e <= wd_q[15:0];
                4'h4: tbl_q[sel_q[9:8]][sel_q[6:0]].vdc_s <= wd_q[15:0];
                4'h5: tbl_q[sel_q[9:8]][sel_q[6:0]].vdc_e <= wd_q[15:0];
                4'h6: tbl_q[sel_q[9:8]][sel_q[6:0]].deg <= wd_q[15:0];
                4'h7: tbl_q[sel_q[9:8]][sel_q[6:0]].dur <= wd_q[15:0];
                default: tbl_q[sel_q[9:8]][sel_q[6:0]].wave <= wd_q[0];
            endcase
        end
    end

    // read data, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        logic [3:0] f;
        f = 4'(araddr[7:2] - LMS_A_FLD[7:2]);
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata_q <= 32'h0000_0000;
            if (araddr[7:2] == LMS_A_CTRL[7:2]) begin
                rdata_q <= {27'h0000000, ctrl_q};
            end else if (araddr[7:2] == LMS_A_COUNT[7:2]) begin
                rdata_q <= {16'h0000, count_q};
            end else if (araddr[7:2] == LMS_A_STAT[7:2]) begin
                rdata_q <= {rep_q, 8'h00, idx_q, st_q};
            end else if (araddr[7:2] == LMS_A_SEL[7:2]) begin
                rdata_q <= {22'h000000, sel_q};
            end else if (araddr >= LMS_A_FLD && f < LMS_NFLD
                         && sel_q[6:0] < LMS_NENT
                         && sel_q[9:8] != 2'b11) begin
                rdata_q <= {16'h0000,
                            get_fld(tbl_q[sel_q[9:8]][sel_q[6:0]], f)};
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    assign mode = lms_trig_e'(ctrl_q[1:0]);
    // software trigger in auto/manual, rising edge in external
    assign trig = (mode == LMS_TRIG_EXT) ? (ext_trig && !ext_q)
                                         : sw_trig;
    assign tick = tick_q == 32'(TICK_CYC - 1);
    assign wrap = tick && acc_d[0] < acc_q[0];
    assign step = ctrl_q[LMS_C_BASE] ? wrap : tick;
    assign last = step && el_q + 16'h0001 >= tbl_q[0][idx_q].dur;
    assign nidx = idx_q + 7'h01;
    // list ends at the table end or a zero duration entry
    assign pass_end = nidx == LMS_NENT
                      || tbl_q[0][nidx].dur == 16'h0000;
    assign run_end = pass_end && (mode == LMS_TRIG_MANUAL
                     || (count_q != 16'h0000
                         && rep_q + 16'h0001 >= count_q));
    assign ent_go = (st_q == LMS_IDLE && trig)
                    || (st_q == LMS_RUN && last && !run_end && !sw_stop);
    assign go_idx = (st_q == LMS_IDLE || pass_end) ? 7'h00 : nidx;

    // edge detect of the external trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_trig;
        end
    end

    // ms prescaler, restarts at each run start
    always_ff @(posedge aclk) begin
        if (!aresetn || st_q == LMS_IDLE || tick) begin
            tick_q <= 32'h0000_0000;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
        end
    end

    // run state, entry index, repeat and elapsed counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= LMS_IDLE;
            idx_q <= 7'h00;
            rep_q <= 16'h0000;
            el_q <= 16'h0000;
        end else if (st_q == LMS_IDLE) begin
            // a run needs a non zero first entry
            if (trig && tbl_q[0][0].dur != 16'h0000) begin
                st_q <= LMS_RUN;
                idx_q <= 7'h00;
                rep_q <= 16'h0000;
                el_q <= 16'h0000;
            end
        end else if (sw_stop || (last && run_end)) begin
            st_q <= LMS_IDLE;
        end else if (last) begin
            idx_q <= go_idx;
            el_q <= 16'h0000;
            if (pass_end) begin
                rep_q <= rep_q + 16'h0001;
            end
        end else if (step) begin
            el_q <= el_q + 16'h0001;
        end
        // triggers during a run fall through unused
    end

    assign out_en = st_q == LMS_RUN;

    // ------------------------------------------------------------
    // per phase setpoints
    // ------------------------------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_ph
        // joint coupling reads phase one entries
        localparam logic [1:0] PI = 2'(p);
        logic [1:0] src; // entry set in use
        lms_entry_s e; // current entry
        lms_entry_s g; // entry beginning now
        logic [15:0] fq; // current frequency
        logic [15:0] off; // entry zero displacement
        assign src = ctrl_q[LMS_C_COUPLE] ? 2'b00 : PI;
        assign e = tbl_q[src][idx_q];
        assign g = tbl_q[src][go_idx];
        assign off = (p == 1) ? LMS_OFF_P2
                   : (p == 2) ? LMS_OFF_P3 : 16'h0000;
        assign fq = lerp(e.f_s, e.f_e, el_q, e.dur);
        // both factors widened first so the product keeps all its bits
        assign acc_d[p] = acc_q[p]
                          + (32'(fq) * 32'(LMS_PHASE_K));

        // angle: load at entry start unless continuing
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                acc_q[p] <= 32'h0000_0000;
            end else if (ent_go && (st_q == LMS_IDLE
                         || !ctrl_q[LMS_C_CONT])) begin
                acc_q[p] <= {go_idx == 7'h00 && p != 0
                             ? tbl_q[0][7'h00].deg + off
                             : g.deg, 16'h0000};
            end else if (st_q == LMS_RUN && idx_q == 7'h00 && p != 0) begin
                acc_q[p] <= acc_d[0] + {off, 16'h0000};
            end else if (st_q == LMS_RUN && tick) begin
                acc_q[p] <= acc_d[p];
            end
        end

        // registered setpoints, zero while idle
        always_ff @(posedge aclk) begin
            if (!aresetn || st_q == LMS_IDLE) begin
                ph_out[p] <= '0;
            end else begin
                ph_out[p].vac <= lerp(e.vac_s, e.vac_e, el_q, e.dur);
                ph_out[p].vdc <= lerp(e.vdc_s, e.vdc_e, el_q, e.dur);
                ph_out[p].freq <= fq;
                ph_out[p].angle <= acc_q[p][31:16];
                ph_out[p].wave <= e.wave;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_start;
        st_q == LMS_IDLE && trig && tbl_q[0][0].dur != 16'h0000;
    endsequence
    sequence s_running;
        st_q == LMS_RUN && idx_q == 7'h00;
    endsequence
    AST_START: assert property (@(posedge aclk)
        disable iff (!aresetn) s_start |=> s_running)
        else $error("run did not start");
    AST_ZERO: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_IDLE && trig && tbl_q[0][0].dur == 16'h0000
        |=> st_q == LMS_IDLE) else $error("zero entry ran");
    AST_MANUAL: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && mode == LMS_TRIG_MANUAL && last && pass_end
        |=> st_q == LMS_IDLE) else $error("manual ran twice");
    AST_INF: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && count_q == 16'h0000 && mode == LMS_TRIG_AUTO
        && last && pass_end && !sw_stop |=> s_running)
        else $error("endless run ended");
    AST_STOP: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && sw_stop |=> !out_en ##1 !out_en)
        else $error("stop ignored");
    // setpoints fall to zero one edge after the run goes idle
    AST_IDLE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !out_en |=> ph_out[0] == '0 && ph_out[1] == '0
        && ph_out[2] == '0) else $error("setpoints live while idle");
    AST_IGN: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && trig && !last && !sw_stop
        |=> $stable(idx_q)) else $error("trigger restarted");
    AST_ADV: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && last && !pass_end && !sw_stop
        |=> idx_q == $past(idx_q) + 7'h01 && el_q == 16'h0000)
        else $error("entry did not advance");
    AST_JOINT: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == LMS_RUN && ctrl_q[LMS_C_COUPLE] && idx_q != 7'h00
        ##1 st_q == LMS_RUN |-> ph_out[1].vac == ph_out[0].vac)
        else $error("coupling broken");
    // with continuity the next entry keeps the advanced angle
    AST_CONT: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ent_go && st_q == LMS_RUN && ctrl_q[LMS_C_CONT]
        |=> acc_q[0] == $past(acc_d[0]))
        else $error("angle not carried over");
endmodule : lms_seq

/* verif/list_mode_sequencer_tb_top.sv */
/*
 * list_mode_sequencer_tb_top: self-checking bench of lms_seq.
 * assumes lms_pkg; duration tick shortened to 10 cycles.
 */
`timescale 1ns/10ps
module list_mode_sequencer_tb_top;
    import lms_pkg::*;
    // --------------------------------------------------------------
    // signals and instances
    // --------------------------------------------------------------
    localparam int TICK = 10; // cycles per duration tick
    logic aclk = 1'b0, aresetn = 1'b0; // clock, reset
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // write side
    logic arvalid = 1'b0, rready = 1'b0; // read side
    logic [7:0] awaddr = 8'h00, araddr = 8'h00; // addresses
    logic [31:0] wdata = 32'h0, rdata; // data
    logic awready, wready, bvalid, arready, rvalid, out_en; // answers
    logic [1:0] bresp, rresp; // responses, unused
    logic ext_trig; // from the trigger model
    lms_out_s ph_out [3]; // per phase setpoints
    int mismatches, checks_done, en_cnt, cyc, t0, p, d0, d1; // counters
    logic [15:0] vs; // random start amplitude
    logic [31:0] r; // read value
    lms_seq #(.TICK_CYC(TICK)) u_lms_seq (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .ext_trig(ext_trig), .out_en(out_en), .ph_out(ph_out));
    lms_trig_src u_lms_trig_src (.aclk(aclk), .ext_trig(ext_trig));
    // clock, enable-time counter and hang limit
    initial forever #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (out_en === 1'b1) en_cnt <= en_cnt + 1;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // expected cycles of enable for n passes over entries 0 and 1
    function automatic int list_cyc(input int n);
        return n * (d0 + d1) * TICK;
    endfunction : list_cyc
    // value compare
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // range compare, unknown fails
    task automatic chk_rng(input logic [31:0] g, input int lo, hi);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t got %0d outside %0d..%0d", $time, g, lo, hi);
        end
    endtask : chk_rng
    // axi4-lite write; handshakes judged mid-cycle, acted on at the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 100 && !tb; n++) begin
            @(negedge aclk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            tb = bvalid === 1'b1;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!tb) mismatches++;
    endtask : wr
    // axi4-lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ta, tr;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 100 && !tr; n++) begin
            @(negedge aclk);
            ta = arvalid && arready === 1'b1;
            tr = rvalid === 1'b1;
            d = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!tr) mismatches++;
    endtask : rd
    // program one entry of one phase, amplitude ramps up by 0x64
    task automatic ent(input int e, ph, input logic [15:0] v, dg, du);
        logic [15:0] f [9];
        f = '{v, v + 16'h0064, 16'h1388, 16'h1388, 16'h0000, 16'h0000,
            dg, du, 16'(e == 0 && ph == 0)};
        wr(LMS_A_SEL, 32'(ph * 256 + e));
        for (int i = 0; i < 9; i++) wr(LMS_A_FLD + 8'(4 * i), {16'h0, f[i]});
    endtask : ent
    // set mode and count, then trigger by command or by the ttl line
    task automatic go(input logic [31:0] c, n);
        wr(LMS_A_CTRL, c);
        wr(LMS_A_COUNT, n);
        t0 = en_cnt;
        if (c[1:0] == 2'b10) u_lms_trig_src.fire(2);
        else wr(LMS_A_CMD, 32'h00000001);
    endtask : go
    // wait for the run to end and judge its length in cycles
    task automatic span(input int lo, hi);
        for (int n = 0; n < 5000 && out_en !== 1'b0; n++) @(negedge aclk);
        chk_rng(en_cnt - t0, lo, hi);
    endtask : span
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(32'hBDD8));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        vs = 16'($urandom_range(4096, 32768));
        d0 = $urandom_range(1, 4);
        d1 = $urandom_range(1, 4);
        p = list_cyc(1);
        chk(out_en, 1'b0);
        rd(LMS_A_COUNT, r);
        chk(r, 32'h00000001);
        rd(8'h44, r);
        chk(r, 32'h00000000);
        for (int ph = 0; ph < 3; ph++) begin
            ent(0, ph, ph == 0 ? vs : 16'(256 * ph), 16'h4000, 16'(d0));
            ent(1, ph, ph == 0 ? vs : 16'(256 * ph), 16'h0000, 16'(d1));
            ent(2, ph, 16'h0000, 16'h0000, 16'h0000);
        end
        go(32'h0, 32'h2);
        @(negedge aclk);
        chk(ph_out[0].angle, 16'h4000);
        chk(ph_out[1].angle, 16'h4000 + LMS_OFF_P2);
        chk(ph_out[2].angle, 16'h4000 + LMS_OFF_P3);
        chk_rng(ph_out[0].vac, vs, vs + 16'h0064);
        chk_rng(ph_out[1].vac, 16'h0100, 16'h0164);
        chk(ph_out[0].wave, 1'b1);
        chk(ph_out[1].wave, 1'b0);
        chk(ph_out[0].freq, 16'h1388);
        wr(LMS_A_CMD, 32'h00000001);
        span(2 * p - 3, 2 * p + 3);
        // setpoints are registered: zero one edge after enable drops
        @(negedge aclk);
        chk(ph_out[0].vac, 16'h0000);
        go(32'h4, 32'h1);
        @(negedge aclk);
        chk_rng(ph_out[1].vac, vs, vs + 16'h0064);
        span(p - 3, p + 3);
        go(32'h1, 32'h3);
        span(p - 3, p + 3);
        go(32'h2, 32'h1);
        span(p - 3, p + 3);
        go(32'h10, 32'h1);
        span((d0 + d1 - 2) * 20 * TICK, (d0 + d1) * 20 * TICK + 20);
        go(32'h8, 32'h0);
        repeat (3 * p) @(negedge aclk);
        chk(out_en, 1'b1);
        wr(LMS_A_CMD, 32'h00000002);
        @(negedge aclk);
        chk(out_en, 1'b0);
        wr(LMS_A_SEL, 32'h00000000);
        wr(LMS_A_FLD + 8'h1C, 32'h00000000);
        go(32'h0, 32'h1);
        repeat (3) @(negedge aclk);
        chk(out_en, 1'b0);
        test_done();
    end
endmodule : list_mode_sequencer_tb_top

/* verif/lms_trig_src.sv */
/*
 * lms_trig_src: model of the external trigger source on the ttl input.
 * assumes the bench calls fire() from a process synchronous to aclk.
 */
`timescale 1ns/10ps
module lms_trig_src (
    input wire logic aclk, // sequencer clock
    output logic ext_trig // trigger line, active high
);
    // --------------------------------------------------------------
    // pulse generator
    // --------------------------------------------------------------
    // line idles low between pulses
    initial ext_trig = 1'b0;
    // one rising edge held n cycles requests a run
    task automatic fire(input int n);
        @(posedge aclk);
        ext_trig <= 1'b1;
        repeat (n) @(posedge aclk);
        ext_trig <= 1'b0;
    endtask : fire
endmodule : lms_trig_src
